// File: src/police_map_pkg.sv
// Package: register map, field layout and reset values of the ingress policing bank
package police_map_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] POINTER_OFFSET = 12'h804;
  localparam logic [11:0] PRIO_MAP_OFFSET = 12'h808;
  localparam logic [11:0] CONTROL_OFFSET = 12'h80c;
  localparam logic [11:0] RATE_OFFSET = 12'h820;
  localparam logic [11:0] BURST_OFFSET = 12'h824;
  localparam logic [11:0] MONITOR_OFFSET = 12'h828;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PORT_INDEX_LSB = 16;
  localparam int PORT_INDEX_W = 3;
  localparam int QUEUE_SEL_LSB = 0;
  localparam int QUEUE_SEL_W = 2;
  localparam int PRIO_FIELD_W = 4;
  localparam int CONTROL_W = 12;
  localparam int HIGH_HALF_LSB = 16;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] PRIO_MAP_RESET = 32'h3322_1100;
  localparam logic [11:0] CONTROL_RESET = 12'h020;
  localparam logic [15:0] CIR_RESET = 16'h1000;
  localparam logic [15:0] PIR_RESET = 16'h2000;
  localparam logic [15:0] CBS_RESET = 16'h1000;
  localparam logic [15:0] PBS_RESET = 16'h3000;

  // Police control layout, bit 11 down to bit 0
  typedef struct packed {
    logic count_dropped_only;
    logic drop_all_over_max;
    logic [1:0] monitor_select;
    logic port_based;
    logic [1:0] non_ip_frame_color;
    logic color_mark_en;
    logic color_remap_en;
    logic srp_drop_allowed;
    logic color_blind;
    logic police_en;
  } control_t;

  // Per port and queue limits
  typedef struct packed {
    logic [15:0] cir;
    logic [15:0] pir;
    logic [15:0] cbs;
    logic [15:0] pbs;
  } limits_t;
endpackage

// File: src/ingress_police_queue_map.sv
// Ingress policing and priority-to-queue configuration bank with classic Wishbone slave
// How it works
// RULE1: Pointer bits 18:16 pick one of six ports
// RULE2: Pointer bits 1:0 pick queue, reset zero
// RULE3: Eight four-bit priority fields, low two used
// RULE4: Reset map 7,6->3 5,4->2 3,2->1 1,0->0
// RULE5: Bit 11 counts only dropped packets per colour
// RULE6: Bit 10 drops all above memory maximum
// RULE7: Bits 9:8 pick monitor counter colour
// RULE8: Bit 7 per-port policing, else port zero
// RULE9: Bits 6:5 non-IP frame colour, reset 01
// RULE10: Bit 4 enables DSCP colour marking
// RULE11: Bit 3 enables DSCP colour remapping
// RULE12: Bit 2 allows WRED drop of SRP
// RULE13: Bit 1 colour-blind, clear colour-aware
// RULE14: Bit 0 enables policing and WRED, reset off
// RULE15: Rate bits 31:16 committed rate, reset 1000
// RULE16: Rate bits 15:0 peak rate, reset 2000
// RULE17: Burst bits 31:16 committed burst, reset 1000
// RULE18: Burst bits 15:0 peak burst, reset 3000
// RULE19: Reserved pointer and control bits read zero
// RULE20: Software sets pointer before rate access
`timescale 1ns/100ps
module ingress_police_queue_map #(
  parameter int NUM_PORTS = 6,
  parameter int NUM_QUEUES = 4,
  parameter int COUNTER_W = 24
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Selected queue's counters from the datapath meter (same clock)
  input wire logic [COUNTER_W-1:0] red_count_i,
  input wire logic [COUNTER_W-1:0] yellow_count_i,
  input wire logic [COUNTER_W-1:0] green_count_i,
  input wire logic [COUNTER_W-1:0] dropped_count_i,
  // Priority lookup port for the ingress datapath
  input wire logic [2:0] lookup_priority_i,
  output logic [1:0] lookup_queue_o,
  // Configuration driven to the policer and WRED logic
  output police_map_pkg::control_t control_o,
  output logic [2:0] police_port_o,
  output logic [1:0] police_queue_o,
  output police_map_pkg::limits_t limits_o
);
  localparam int ENTRIES = NUM_PORTS * NUM_QUEUES;
  localparam logic [4:0] LAST_ENTRY = 5'(ENTRIES - 1);
  localparam police_map_pkg::limits_t LIMITS_RESET = '{
    cir: police_map_pkg::CIR_RESET,
    pir: police_map_pkg::PIR_RESET,
    cbs: police_map_pkg::CBS_RESET,
    pbs: police_map_pkg::PBS_RESET
  };

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic req;
  logic wr;
  logic hit;
  logic [31:0] rd_data;
  logic [2:0] port_q;
  logic [1:0] queue_q;
  logic [31:0] prio_map_q;
  police_map_pkg::control_t control_q;
  police_map_pkg::limits_t limits_q [ENTRIES];
  logic [31:0] rate_word;
  logic [31:0] burst_word;
  logic [COUNTER_W-1:0] monitor_value;
  logic [4:0] sel_entry;
  logic [4:0] eff_entry;
  logic entry_ok;
  logic eff_ok;
  logic wr_pointer;
  logic wr_prio;
  logic wr_control;
  logic wr_rate;
  logic wr_burst;
  logic [31:0] control_merged;
  logic [1:0] prio_queue [8];

  // Indirect entry from port and queue; per-queue mode uses port zero for the policer entry, while bus access keeps the pointer port
  function automatic logic [4:0] entry_of(input logic [2:0] port, input logic [1:0] queue,
                                          input logic per_port);
    logic [4:0] idx;
    idx = per_port ? {port, queue} : {3'h0, queue}; // RULE8
    return idx;
  endfunction

  // Merge write data under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Write strobe for one register offset
  function automatic logic write_to(input logic wr_req, input logic [11:0] adr,
                                    input logic [11:0] offset);
    return wr_req && (adr == offset);
  endfunction

  // Ports six and seven lie beyond the table: reads give zero, writes are lost
  function automatic logic in_table(input logic [4:0] idx);
    return idx <= LAST_ENTRY;
  endfunction

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr = req && wb_we_i && hit;
  assign sel_entry = entry_of(port_q, queue_q, 1'b1); // RULE20
  assign eff_entry = entry_of(port_q, queue_q, control_q.port_based); // RULE8
  assign entry_ok = in_table(sel_entry); // RULE1
  assign eff_ok = in_table(eff_entry); // RULE1
  assign wr_pointer = write_to(wr, wb_adr_i, police_map_pkg::POINTER_OFFSET);
  assign wr_prio = write_to(wr, wb_adr_i, police_map_pkg::PRIO_MAP_OFFSET);
  assign wr_control = write_to(wr, wb_adr_i, police_map_pkg::CONTROL_OFFSET);
  assign wr_rate = write_to(wr, wb_adr_i, police_map_pkg::RATE_OFFSET);
  assign wr_burst = write_to(wr, wb_adr_i, police_map_pkg::BURST_OFFSET);

  always_comb
  begin
    hit = 1'b1;
    unique case (wb_adr_i)
      police_map_pkg::POINTER_OFFSET,
      police_map_pkg::PRIO_MAP_OFFSET,
      police_map_pkg::CONTROL_OFFSET,
      police_map_pkg::RATE_OFFSET,
      police_map_pkg::BURST_OFFSET,
      police_map_pkg::MONITOR_OFFSET: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Pointer register
  // ----------------------------------------------------------------
  // Port index and queue selector sit in separate byte lanes, each with its own enable
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      port_q <= 3'h0;
    end
    else if (wr_pointer && wb_sel_i[2])
    begin
      port_q <= wb_dat_i[police_map_pkg::PORT_INDEX_LSB +: police_map_pkg::PORT_INDEX_W]; // RULE1
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      queue_q <= 2'h0; // RULE2
    end
    else if (wr_pointer && wb_sel_i[0])
    begin
      queue_q <= wb_dat_i[police_map_pkg::QUEUE_SEL_LSB +: police_map_pkg::QUEUE_SEL_W]; // RULE2
    end
  end

  // ----------------------------------------------------------------
  // Priority map and control
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      prio_map_q <= police_map_pkg::PRIO_MAP_RESET; // RULE4
    end
    else if (wr_prio)
    begin
      prio_map_q <= merge(prio_map_q, wb_dat_i, wb_sel_i); // RULE3
    end
  end

  // Bits 31:12 are dropped below and read back as zero
  assign control_merged = merge({20'h00000, control_q}, wb_dat_i, wb_sel_i);

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      control_q <= police_map_pkg::control_t'(police_map_pkg::CONTROL_RESET); // RULE9 RULE14
    end
    else if (wr_control)
    begin
      control_q <= police_map_pkg::control_t'(
        control_merged[police_map_pkg::CONTROL_W-1:0]); // RULE19
    end
  end

  // ----------------------------------------------------------------
  // Indirect rate and burst table
  // ----------------------------------------------------------------
  assign rate_word = entry_ok ? {limits_q[sel_entry].cir, limits_q[sel_entry].pir}
                              : 32'h0000_0000; // RULE1
  assign burst_word = entry_ok ? {limits_q[sel_entry].cbs, limits_q[sel_entry].pbs}
                               : 32'h0000_0000; // RULE1

  generate
    for (genvar e = 0; e < ENTRIES; e++)
    begin : g_entry
      always_ff @(posedge clock_i)
      begin
        if (!resetn_i)
        begin
          limits_q[e].cir <= police_map_pkg::CIR_RESET; // RULE15
          limits_q[e].pir <= police_map_pkg::PIR_RESET; // RULE16
          limits_q[e].cbs <= police_map_pkg::CBS_RESET; // RULE17
          limits_q[e].pbs <= police_map_pkg::PBS_RESET; // RULE18
        end
        else if (sel_entry == 5'(e))
        begin
          if (wr_rate)
          begin
            {limits_q[e].cir, limits_q[e].pir} <= merge(rate_word, wb_dat_i, wb_sel_i); // RULE15 RULE16
          end
          if (wr_burst)
          begin
            {limits_q[e].cbs, limits_q[e].pbs} <= merge(burst_word, wb_dat_i, wb_sel_i); // RULE17 RULE18
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux and answer
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (control_q.monitor_select) // RULE7
      2'b11: monitor_value = red_count_i;
      2'b10: monitor_value = yellow_count_i;
      2'b01: monitor_value = green_count_i;
      2'b00: monitor_value = dropped_count_i;
    endcase
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      police_map_pkg::POINTER_OFFSET: rd_data = {13'h0000, port_q, 14'h0000, queue_q}; // RULE19
      police_map_pkg::PRIO_MAP_OFFSET: rd_data = prio_map_q;
      police_map_pkg::CONTROL_OFFSET: rd_data = {20'h00000, control_q};
      police_map_pkg::RATE_OFFSET: rd_data = rate_word;
      police_map_pkg::BURST_OFFSET: rd_data = burst_word;
      police_map_pkg::MONITOR_OFFSET: rd_data = 32'(monitor_value);
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus answer: one wait state, the cycle after the request is seen
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= req && hit;
    end
  end

  // Unmapped offsets are refused with an error instead of an acknowledge
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      wb_err_o <= 1'b0;
    end
    else
    begin
      wb_err_o <= req && !hit;
    end
  end

  // Data stays zero outside a read answer so a stale word never leaks out
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_dat_o <= (req && hit && !wb_we_i) ? rd_data : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the datapath
  // ----------------------------------------------------------------
  // Only the low two bits of each nibble carry the queue
  generate
    for (genvar p = 0; p < 8; p++)
    begin : g_prio
      assign prio_queue[p] = prio_map_q[p * police_map_pkg::PRIO_FIELD_W +: 2]; // RULE3
    end
  endgenerate

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      lookup_queue_o <= 2'h0;
    end
    else
    begin
      lookup_queue_o <= prio_queue[lookup_priority_i]; // RULE3 RULE4
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      control_o <= police_map_pkg::control_t'(police_map_pkg::CONTROL_RESET);
    end
    else
    begin
      control_o <= control_q; // RULE5 RULE6 RULE10 RULE11 RULE12 RULE13 RULE14
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      police_port_o <= 3'h0;
    end
    else
    begin
      police_port_o <= control_q.port_based ? port_q : 3'h0; // RULE8
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      police_queue_o <= 2'h0;
    end
    else
    begin
      police_queue_o <= queue_q; // RULE2
    end
  end

  // An index past the table shows the reset limits rather than an unknown entry
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      limits_o <= LIMITS_RESET;
    end
    else
    begin
      limits_o <= eff_ok ? limits_q[eff_entry] : LIMITS_RESET; // RULE8
    end
  end
endmodule

// File: verification/ingress_police_queue_map_assertions.sv
// Checker for the ingress policing bank, bound to its top module
`timescale 1ns/100ps
module ingress_police_queue_map_assertions (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [2:0] lookup_priority_i,
  input wire logic [1:0] lookup_queue_o,
  input wire police_map_pkg::control_t control_o,
  input wire logic [2:0] police_port_o,
  input wire logic [1:0] police_queue_o,
  input wire police_map_pkg::limits_t limits_o
);
  wire wr_ctl = wb_ack_o && wb_we_i && wb_adr_i == 12'h80c;
  wire wr_ptr = wb_ack_o && wb_we_i && wb_adr_i == 12'h804;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  a_answer_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o ^ wb_err_o) else $error("request not answered once in the next cycle");
  a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside acknowledge");
  a_port_agg: assert property (!control_o.port_based |-> police_port_o == 3'h0)
    else $error("port index not zero while policing per queue");
  a_lookup_reset: assert property (disable iff (1'b0) !resetn_i ##1 resetn_i
    |=> lookup_queue_o == $past(lookup_priority_i) >> 1) else $error("reset map wrong");
  a_reset_ctrl: assert property (disable iff (1'b0) !resetn_i
    |=> control_o == 12'h020 && police_queue_o == 2'h0) else $error("control reset wrong");
  a_reset_limits: assert property (disable iff (1'b0) !resetn_i
    |=> limits_o == 64'h1000_2000_1000_3000) else $error("limits reset wrong");
  a_ctrl_cause: assert property ($changed(control_o) |-> $past(wr_ctl) || $past(wr_ctl, 2))
    else $error("control changed without a write");
  a_queue_cause: assert property ($changed(police_queue_o)
    |-> $past(wr_ptr) || $past(wr_ptr, 2)) else $error("queue changed without a write");
  c_err: cover property (wb_err_o);
  c_ctl: cover property (wr_ctl);
  c_port: cover property (control_o.port_based && police_port_o != 3'h0);
endmodule
bind ingress_police_queue_map ingress_police_queue_map_assertions u_chk (.clock_i, .resetn_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
  .lookup_priority_i, .lookup_queue_o, .control_o, .police_port_o, .police_queue_o, .limits_o);

// File: verification/test_ingress_police_queue_map.sv
// Self-checking bench for the ingress policing bank
`timescale 1ns/100ps
module test_ingress_police_queue_map;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [23:0] cnt [4] = '{4{24'h0}};
  logic [2:0] prio = 3'h7;
  logic [31:0] wb_dat_o, rd, ctl, map;
  logic wb_ack_o, wb_err_o, err;
  logic [1:0] lookup_queue_o, police_queue_o;
  logic [2:0] police_port_o;
  police_map_pkg::control_t control_o;
  police_map_pkg::limits_t limits_o;
  logic [31:0] rate [6][4];
  logic [31:0] burst [6][4];
  int miscompares = 0;
  int n_tests = 0;
  ingress_police_queue_map u_ingress_police_queue_map (.clock_i, .resetn_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
    .red_count_i(cnt[3]), .yellow_count_i(cnt[2]), .green_count_i(cnt[1]),
    .dropped_count_i(cnt[0]), .lookup_priority_i(prio), .lookup_queue_o, .control_o,
    .police_port_o, .police_queue_o, .limits_o);
  initial forever #25 clock_i = ~clock_i;
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until ack or err is sampled, then idles one cycle
  task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do
    begin
      @(posedge clock_i);
    end
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    rd = wb_dat_o;
    err = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    check(rd, exp);
  endtask
  initial
  begin
    #(50 * 20000);
    miscompares++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(52));
    repeat (16) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    rdchk(12'h804, 32'h0);
    rdchk(12'h808, 32'h3322_1100);
    rdchk(12'h80c, 32'h20);
    rdchk(12'h820, 32'h1000_2000);
    rdchk(12'h824, 32'h1000_3000);
    bus(1'b1, 12'h810, 32'hffff_ffff, 4'hf);
    check(err, 1'b1);
    wr(12'h804, 32'hffff_ffff);
    rdchk(12'h804, 32'h0007_0003);
    wr(12'h804, 32'h0005_0002);
    for (int i = 0; i < 8; i++)
    begin
      ctl = $urandom();
      ctl[9:8] = i[1:0];
      for (int j = 0; j < 4; j++)
        cnt[j] <= 24'($urandom());
      wr(12'h80c, ctl);
      rdchk(12'h80c, {20'h0, ctl[11:0]});
      check(control_o, ctl[11:0]);
      check({police_port_o, police_queue_o}, {ctl[7] ? 3'h5 : 3'h0, 2'h2});
      rdchk(12'h828, {8'h0, cnt[ctl[9:8]]});
    end
    map = $urandom();
    wr(12'h808, map);
    rdchk(12'h808, map);
    bus(1'b1, 12'h808, ~map, 4'h2);
    rdchk(12'h808, {map[31:16], ~map[15:8], map[7:0]});
    map[15:8] = ~map[15:8];
    for (int p = 0; p < 8; p++)
    begin
      prio <= 3'(p);
      repeat (2) @(posedge clock_i);
      check(lookup_queue_o, map[4 * p +: 2]);
    end
    wr(12'h80c, 32'h80);
    for (int k = 0; k < 48; k++)
    begin
      wr(12'h804, 32'(((k % 24) / 4 << 16) | k % 4));
      if (k < 24)
      begin
        rate[k / 4][k % 4] = $urandom();
        burst[k / 4][k % 4] = $urandom();
        wr(12'h820, rate[k / 4][k % 4]);
        wr(12'h824, burst[k / 4][k % 4]);
      end
      else
      begin
        rdchk(12'h820, rate[k / 4 - 6][k % 4]);
        rdchk(12'h824, burst[k / 4 - 6][k % 4]);
        check(limits_o, {rate[k / 4 - 6][k % 4], burst[k / 4 - 6][k % 4]});
      end
    end
    wr(12'h80c, 32'h0);
    for (int q = 0; q < 4; q++)
    begin
      wr(12'h804, 32'h0003_0000 | q);
      rdchk(12'h820, rate[3][q]);
      check(limits_o, {rate[0][q], burst[0][q]});
    end
    end_of_test();
  end
endmodule
